// File: bench/osp_checker.sv
`timescale 1ns/1ps
module osp_checker import osp_pkg::*; #(
  parameter int unsigned TX_PULSE_CYC = OSP_TX_PULSE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register bus
  input wire logic [OSP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // pins and output state
  input wire logic syncOnPinOut,
  input wire logic syncOnPinOe,
  input wire logic syncOffPinOut,
  input wire logic syncOffPinOe,
  input wire logic outputOn
);
  logic [31:0] cfg0_ff;
  logic [31:0] cfg1_ff;
  logic [3:0] age_ff;
  logic [15:0] txCnt_ff;
  logic wrCfg;
  logic sync0;
  logic sync1;
  assign wrCfg = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr[7:3] == 5'h00;
  assign sync0 = cfg0_ff[1:0] == 2'h0 && age_ff > 4'h8;
  assign sync1 = cfg1_ff[1:0] == 2'h0 && age_ff > 4'h8;
  // shadow of the pin settings, age counts cycles since the last change
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg0_ff <= 32'h0;
      cfg1_ff <= 32'h0;
      age_ff <= 4'h0;
      txCnt_ff <= 16'h0;
    end else begin
      if (wrCfg && !s_axi_awaddr[2]) cfg0_ff <= s_axi_wdata;
      if (wrCfg && s_axi_awaddr[2]) cfg1_ff <= s_axi_wdata;
      age_ff <= wrCfg ? 4'h0 : (age_ff == 4'hF ? age_ff : age_ff + 4'h1);
      txCnt_ff <= syncOnPinOe ? txCnt_ff + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_onEmit;
    $rose(outputOn) && sync0 |-> syncOnPinOe && syncOnPinOut == cfg0_ff[2];
  endproperty
  a_onEmit: assert property (p_onEmit) else $error("no turn-on pulse");
  property p_offEmit;
    $fell(outputOn) && sync1 |-> syncOffPinOe && syncOffPinOut == cfg1_ff[2];
  endproperty
  a_offEmit: assert property (p_offEmit) else $error("no turn-off pulse");
  property p_onWidth;
    $fell(syncOnPinOe) && sync0 |-> txCnt_ff == TX_PULSE_CYC;
  endproperty
  a_onWidth: assert property (p_onWidth) else $error("sync pulse width");
  property p_genOut;
    cfg0_ff[1:0] == 2'h2 && !cfg0_ff[5] && age_ff > 4'h4
      |-> syncOnPinOe && syncOnPinOut == (cfg0_ff[2] ~^ cfg0_ff[4]);
  endproperty
  a_genOut: assert property (p_genOut) else $error("output level");
  property p_inputOe;
    cfg0_ff[0] && age_ff > 4'h4 |-> !syncOnPinOe;
  endproperty
  a_inputOe: assert property (p_inputOe) else $error("input pin driven");
  property p_bLat;
    s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_bLat: assert property (p_bLat) else $error("late write response");
  property p_rLat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rLat: assert property (p_rLat) else $error("late read data");
  property p_arWait;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arWait: assert property (p_arWait) else $error("second read accepted");
  c_on: cover property ($rose(outputOn));
  c_off: cover property ($fell(outputOn));
  c_tx: cover property ($fell(syncOnPinOe) && sync0);
endmodule // osp_checker

bind osp_top osp_checker #(.TX_PULSE_CYC(TX_PULSE_CYC)) u_chk (
  .mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .syncOnPinOut, .syncOnPinOe, .syncOffPinOut, .syncOffPinOe, .outputOn
);

// File: bench/osp_far_end.sv
`timescale 1ns/1ps
module osp_far_end (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // pulse request
  input wire logic fire,
  input wire logic [15:0] width,
  // pin drive, active low, released otherwise
  output logic drvOe,
  output logic drvOut
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  // low level held for the whole requested width
  always_comb nxt_cnt = fire ? width : (cnt_ff != 16'h0 ? cnt_ff - 16'h1 : cnt_ff);
  always_ff @(posedge mclk) cnt_ff <= rstn ? nxt_cnt : 16'h0;
  assign drvOe = cnt_ff != 16'h0;
  assign drvOut = 1'h0;
endmodule // osp_far_end

// File: bench/osp_top_test.sv
`timescale 1ns/1ps
module osp_top_test import osp_pkg::*;;
  localparam int MINC = 8;
  localparam int TXC = 20;
  logic mclk = 1'h0, rstn = 1'h0, ce = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, fire = 2'h0;
  wire [1:0] farOe, farOut;
  logic syncOnPinOut, syncOnPinOe, syncOffPinOut, syncOffPinOe, outputOn, pin0, pin1;
  logic [15:0] farWidth = 16'h0;
  logic [33:0] expR [$];
  logic [1:0] expB [$];
  int n_fail = 0;
  int samples_checked = 0;
  integer seed = 76;
  // pull-up on both lines, device drive wins
  assign pin0 = syncOnPinOe ? syncOnPinOut : (farOe[0] ? farOut[0] : 1'h1);
  assign pin1 = syncOffPinOe ? syncOffPinOut : (farOe[1] ? farOut[1] : 1'h1);
  always #2.5 mclk = ~mclk;
  osp_top #(.MIN_PULSE_CYC(MINC), .TX_PULSE_CYC(TXC)) DUT (.mclk, .rstn, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .syncOnPinIn(pin0), .syncOnPinOut, .syncOnPinOe,
    .syncOffPinIn(pin1), .syncOffPinOut, .syncOffPinOe, .outputOn);
  osp_far_end u_far0 (.mclk, .rstn, .fire(fire[0]), .width(farWidth),
    .drvOe(farOe[0]), .drvOut(farOut[0]));
  osp_far_end u_far1 (.mclk, .rstn, .fire(fire[1]), .width(farWidth),
    .drvOe(farOe[1]), .drvOut(farOut[1]));
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task results;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic awOpen;
    logic wOpen;
    expB.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // local flags: the valid signals still read their old value in this time step
    awOpen = 1'h1;
    wOpen = 1'h1;
    while (awOpen || wOpen) begin
      @(posedge mclk);
      if (awOpen && s_axi_awready) begin
        s_axi_awvalid <= 1'h0;
        awOpen = 1'h0;
      end
      if (wOpen && s_axi_wready) begin
        s_axi_wvalid <= 1'h0;
        wOpen = 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    expR.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  task automatic pulse(input int p, input int w);
    farWidth <= w[15:0];
    fire[p] <= 1'h1;
    @(posedge mclk);
    fire[p] <= 1'h0;
  endtask
  // bus results against the oldest note
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expR.pop_front());
    if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, expB.pop_front()});
  end
  initial begin
    logic [31:0] v;
    logic [7:0] cnt;
    tick(20);
    rstn <= 1'h1;
    tick(2);
    rd(OSP_OFF_PIN0_CFG, OSP_RESP_OKAY, OSP_CFG_RST);
    rd(OSP_OFF_PIN1_CFG, OSP_RESP_OKAY, OSP_CFG_RST);
    rd(OSP_OFF_PIN0_PWM, OSP_RESP_OKAY, OSP_PWM_RST);
    rd(OSP_OFF_PIN1_PWM, OSP_RESP_OKAY, OSP_PWM_RST);
    rd(OSP_OFF_OUT_CTL, OSP_RESP_OKAY, 32'h0);
    wr(OSP_OFF_STATUS, 32'hFF, OSP_RESP_OKAY);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h0);
    rd(8'h18, OSP_RESP_SLVERR, 32'h0);
    rd(8'h02, OSP_RESP_SLVERR, 32'h0);
    wr(8'h18, 32'hFFFFFFFF, OSP_RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      // invert and select kept clear so the pins stay inactive
      v = $random(seed) & 32'hFFFFFFCB;
      wr(OSP_OFF_PIN0_CFG + 8'(4 * i), v, OSP_RESP_OKAY);
      rd(OSP_OFF_PIN0_CFG + 8'(4 * i), OSP_RESP_OKAY, v & OSP_CFG_MASK);
      wr(OSP_OFF_PIN0_CFG + 8'(4 * i), 32'h0, OSP_RESP_OKAY);
      v = $random(seed);
      wr(OSP_OFF_PIN0_PWM + 8'(4 * i), v, OSP_RESP_OKAY);
      rd(OSP_OFF_PIN0_PWM + 8'(4 * i), OSP_RESP_OKAY, v);
    end
    tick(20);
    pulse(0, MINC - 3);
    tick(MINC + TXC + 40);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h0);
    pulse(0, MINC + 4);
    tick(MINC + TXC + 40);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h1);
    pulse(0, MINC + 4);
    tick(MINC + TXC + 40);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h1);
    pulse(1, MINC + 4);
    tick(MINC + TXC + 40);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h0);
    pulse(1, MINC + 4);
    tick(MINC + TXC + 40);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h0);
    wr(OSP_OFF_OUT_CTL, 32'h1, OSP_RESP_OKAY);
    tick(TXC + 10);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h1);
    wr(OSP_OFF_OUT_CTL, 32'h2, OSP_RESP_OKAY);
    tick(TXC + 10);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h0);
    wr(OSP_OFF_PIN0_CFG, 32'h1, OSP_RESP_OKAY);
    tick(4);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h0);
    pulse(0, 40);
    tick(8);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h2);
    wr(OSP_OFF_PIN0_CFG, 32'h5, OSP_RESP_OKAY);
    tick(4);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h0);
    tick(40);
    rd(OSP_OFF_STATUS, OSP_RESP_OKAY, 32'h2);
    for (int i = 0; i < 4; i++) begin
      v = 32'h2 | (32'(i[1]) << 2) | (32'(i[0]) << 4);
      wr(OSP_OFF_PIN0_CFG, v, OSP_RESP_OKAY);
      wr(OSP_OFF_PIN1_CFG, v, OSP_RESP_OKAY);
      tick(4);
      check({32'h0, syncOnPinOe, pin0}, {32'h0, 1'h1, i[0] ~^ i[1]});
      check({32'h0, syncOffPinOe, pin1}, {32'h0, 1'h1, i[0] ~^ i[1]});
    end
    wr(OSP_OFF_PIN0_PWM, 32'h0004000A, OSP_RESP_OKAY);
    wr(OSP_OFF_PIN0_CFG, 32'h22, OSP_RESP_OKAY);
    tick(30);
    cnt = 8'h0;
    repeat (20) begin
      @(posedge mclk);
      cnt = cnt + {7'h0, !pin0};
    end
    check({26'h0, cnt}, 34'h8);
    // clock enable low: the pwm pin must not move at all
    ce <= 1'h0;
    tick(2);
    cnt = 8'h0;
    v[0] = pin0;
    repeat (20) begin
      @(posedge mclk);
      cnt = cnt + {7'h0, pin0 ^ v[0]};
      v[0] = pin0;
    end
    check({26'h0, cnt}, 34'h0);
    ce <= 1'h1;
    tick(2);
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule // osp_top_test

// File: design/osp_pin_rx.sv
`timescale 1ns/1ps
module osp_pin_rx import osp_pkg::*; #(
  parameter int unsigned MIN_CYC = OSP_MIN_PULSE_CYC,
  parameter int unsigned CNT_W = OSP_CNT_W
) (
  // clock
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // pin side
  input wire logic pinIn,
  input wire logic invert,
  // results
  output logic activeLevel,
  output logic pulse
);
  logic [2:0] syncFf, nxt_sync;
  logic stableFf, nxt_stable;
  logic [CNT_W-1:0] cntFf, nxt_cnt;
  logic firedFf, nxt_fired;
  logic pulseFf, nxt_pulse;
  logic levelFf, nxt_level;
  logic act;

  always_comb begin
    nxt_sync = {syncFf[1:0], pinIn};
    nxt_stable = (syncFf[1] == syncFf[2]) ? syncFf[1] : stableFf;
    act = stableFf ^ ~invert;
    nxt_level = act;
    nxt_cnt = cntFf;
    nxt_fired = firedFf;
    nxt_pulse = 1'b0;
    if (!act) begin
      nxt_cnt = '0;
      nxt_fired = 1'b0;
    end else if (!firedFf) begin
      if (cntFf == CNT_W'(MIN_CYC - 1)) begin
        nxt_pulse = 1'b1;
        nxt_fired = 1'b1;
      end else begin
        nxt_cnt = cntFf + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      syncFf <= 3'h7;
      stableFf <= 1'b1;
      cntFf <= '0;
      firedFf <= 1'b0;
      pulseFf <= 1'b0;
      levelFf <= 1'b0;
    end else if (ce) begin
      syncFf <= nxt_sync;
      stableFf <= nxt_stable;
      cntFf <= nxt_cnt;
      firedFf <= nxt_fired;
      pulseFf <= nxt_pulse;
      levelFf <= nxt_level;
    end
  end

  assign activeLevel = levelFf;
  assign pulse = pulseFf;
endmodule // osp_pin_rx

// File: design/osp_pkg.sv
package osp_pkg;

  // bus geometry
  localparam int unsigned OSP_ADDR_W = 8;
  localparam int unsigned OSP_CNT_W = 16;
  localparam int unsigned OSP_NPINS = 2;

  // register byte offsets
  localparam logic [7:0] OSP_OFF_PIN0_CFG = 8'h00;
  localparam logic [7:0] OSP_OFF_PIN1_CFG = 8'h04;
  localparam logic [7:0] OSP_OFF_PIN0_PWM = 8'h08;
  localparam logic [7:0] OSP_OFF_PIN1_PWM = 8'h0C;
  localparam logic [7:0] OSP_OFF_OUT_CTL = 8'h10;
  localparam logic [7:0] OSP_OFF_STATUS = 8'h14;

  // pin config fields
  localparam int unsigned OSP_CFG_MODE_LSB = 0;
  localparam int unsigned OSP_CFG_INV_BIT = 2;
  localparam int unsigned OSP_CFG_SEL_LSB = 4;
  localparam logic [31:0] OSP_CFG_MASK = 32'h00000037;
  localparam logic [31:0] OSP_CFG_RST = 32'h00000000;

  // pwm register fields: period low half, high time upper half
  localparam int unsigned OSP_PWM_PER_LSB = 0;
  localparam int unsigned OSP_PWM_DUTY_LSB = 16;
  localparam logic [31:0] OSP_PWM_RST = 32'h006400C8;

  // output control and status bits
  localparam int unsigned OSP_CTL_ON_BIT = 0;
  localparam int unsigned OSP_CTL_OFF_BIT = 1;
  localparam int unsigned OSP_ST_ON_BIT = 0;
  localparam int unsigned OSP_ST_LVL_LSB = 1;
  localparam int unsigned OSP_ST_TX_LSB = 3;

  // axi responses
  localparam logic [1:0] OSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] OSP_RESP_SLVERR = 2'h2;

  // timing
  localparam int unsigned OSP_CLK_MHZ = 200;
  localparam int unsigned OSP_MIN_PULSE_US = 30;
  localparam int unsigned OSP_TX_PULSE_US = 50;
  localparam int unsigned OSP_MIN_PULSE_CYC = OSP_MIN_PULSE_US * OSP_CLK_MHZ;
  localparam int unsigned OSP_TX_PULSE_CYC = OSP_TX_PULSE_US * OSP_CLK_MHZ;

  typedef enum logic [1:0] {
    OSP_MODE_SYNC = 2'h0,
    OSP_MODE_INPUT = 2'h1,
    OSP_MODE_OUTPUT = 2'h2,
    OSP_MODE_RSVD = 2'h3
  } osp_mode_t;

  typedef enum logic [1:0] {
    OSP_SEL_ZERO = 2'h0,
    OSP_SEL_ONE = 2'h1,
    OSP_SEL_PWM = 2'h2,
    OSP_SEL_RSVD = 2'h3
  } osp_sel_t;

endpackage

// File: design/osp_pwm.sv
`timescale 1ns/1ps
module osp_pwm import osp_pkg::*; #(
  parameter int unsigned W = OSP_CNT_W
) (
  // clock
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // settings in clock cycles
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] duty,
  // waveform
  output logic pwm
);
  logic [W-1:0] cntFf, nxt_cnt;
  logic pwmFf, nxt_pwm;

  always_comb begin
    if (period == '0 || cntFf >= period - 1'b1) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cntFf + 1'b1;
    end
    nxt_pwm = (nxt_cnt < duty);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cntFf <= '0;
      pwmFf <= 1'b0;
    end else if (ce) begin
      cntFf <= nxt_cnt;
      pwmFf <= nxt_pwm;
    end
  end

  assign pwm = pwmFf;
endmodule // osp_pwm

// File: design/osp_top.sv
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - per-pin invert setting flips every received or driven level; default not inverted.
// - first pin defaults to turn-on synchronisation, bidirectional.
// - output going off to on emits a pulse on the first pin.
// - first-pin pulse while output on changes nothing.
// - first-pin pulse while output off turns output on.
// - second pin defaults to turn-off synchronisation, bidirectional.
// - general input mode samples the pin level.
// - general output mode drives logic one, logic zero or PWM.
// - logic one is low when not inverted, high when inverted.
// - logic zero is high when not inverted, low when inverted.
// - output going on to off emits a pulse on the second pin.
// - second-pin pulse while output off changes nothing.
// - second-pin pulse while output on turns output off.
module osp_top import osp_pkg::*; #(
  parameter int unsigned MIN_PULSE_CYC = OSP_MIN_PULSE_CYC,
  parameter int unsigned TX_PULSE_CYC = OSP_TX_PULSE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [OSP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [OSP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // turn-on sync pin
  input wire logic syncOnPinIn,
  output logic syncOnPinOut,
  output logic syncOnPinOe,
  // turn-off sync pin
  input wire logic syncOffPinIn,
  output logic syncOffPinOut,
  output logic syncOffPinOe,
  // instrument output state
  output logic outputOn
);

  // merge write data into a register under byte enables
  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic osp_mode_t cfgMode(input logic [31:0] cfg);
    return osp_mode_t'(cfg[OSP_CFG_MODE_LSB +: 2]);
  endfunction

  // pin drive as {oe, out} from config, pwm bit and sync pulse activity
  function automatic logic [1:0] pinDrive(input logic [31:0] cfg, input logic pwmBit,
                                          input logic txActive);
    logic inv;
    logic val;
    logic [1:0] res;
    inv = cfg[OSP_CFG_INV_BIT];
    val = 1'b0;
    res = 2'b00;
    case (osp_sel_t'(cfg[OSP_CFG_SEL_LSB +: 2]))
      OSP_SEL_ONE: val = 1'b1;
      OSP_SEL_PWM: val = pwmBit;
      default: val = 1'b0;
    endcase
    case (cfgMode(cfg))
      OSP_MODE_SYNC: res = {txActive, inv};
      OSP_MODE_OUTPUT: res = {1'b1, inv ? val : ~val};
      default: res = 2'b00;
    endcase
    return res;
  endfunction

  // configuration and bus state
  logic [OSP_NPINS-1:0][31:0] cfgFf, nxt_cfg;
  logic [OSP_NPINS-1:0][31:0] pwmFf, nxt_pwmReg;
  logic awHaveFf, nxt_awHave;
  logic [OSP_ADDR_W-1:0] awAddrFf, nxt_awAddr;
  logic wHaveFf, nxt_wHave;
  logic [31:0] wDataFf, nxt_wData;
  logic [3:0] wStrbFf, nxt_wStrb;
  logic awreadyFf, nxt_awready;
  logic wreadyFf, nxt_wready;
  logic bvalidFf, nxt_bvalid;
  logic [1:0] brespFf, nxt_bresp;
  logic arreadyFf, nxt_arready;
  logic rvalidFf, nxt_rvalid;
  logic [31:0] rdataFf, nxt_rdata;
  logic [1:0] rrespFf, nxt_rresp;
  logic onReq, offReq;

  // output state and pin drive
  logic outOnFf, nxt_outOn;
  logic [OSP_NPINS-1:0][OSP_CNT_W-1:0] txCntFf, nxt_txCnt;
  logic [OSP_NPINS-1:0] pinOutFf, nxt_pinOut;
  logic [OSP_NPINS-1:0] pinOeFf, nxt_pinOe;
  logic [OSP_NPINS-1:0] pinIn, rxLevel, rxPulse, pwmBit;
  logic [OSP_NPINS-1:0] txActive;
  logic [31:0] statusWord;
  logic turnOn, turnOff;

  assign pinIn = {syncOffPinIn, syncOnPinIn};

  for (genvar i = 0; i < OSP_NPINS; i++) begin : gPin
    osp_pin_rx #(
      .MIN_CYC(MIN_PULSE_CYC),
      .CNT_W(OSP_CNT_W)
    ) uRx (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .pinIn(pinIn[i]),
      .invert(cfgFf[i][OSP_CFG_INV_BIT]),
      .activeLevel(rxLevel[i]),
      .pulse(rxPulse[i])
    );
    osp_pwm #(
      .W(OSP_CNT_W)
    ) uPwm (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .period(pwmFf[i][OSP_PWM_PER_LSB +: OSP_CNT_W]),
      .duty(pwmFf[i][OSP_PWM_DUTY_LSB +: OSP_CNT_W]),
      .pwm(pwmBit[i])
    );
  end

  for (genvar i = 0; i < OSP_NPINS; i++) begin : gTxAct
    assign txActive[i] = (txCntFf[i] != '0);
  end

  always_comb begin
    statusWord = '0;
    statusWord[OSP_ST_ON_BIT] = outOnFf;
    statusWord[OSP_ST_LVL_LSB +: OSP_NPINS] = rxLevel;
    statusWord[OSP_ST_TX_LSB +: OSP_NPINS] = txActive;
  end

  // axi4-lite write side and register writes
  always_comb begin
    nxt_cfg = cfgFf;
    nxt_pwmReg = pwmFf;
    nxt_awHave = awHaveFf;
    nxt_awAddr = awAddrFf;
    nxt_wHave = wHaveFf;
    nxt_wData = wDataFf;
    nxt_wStrb = wStrbFf;
    nxt_bvalid = bvalidFf;
    nxt_bresp = brespFf;
    onReq = 1'b0;
    offReq = 1'b0;
    if (bvalidFf && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_awvalid && awreadyFf) begin
      nxt_awHave = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wreadyFf) begin
      nxt_wHave = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (awHaveFf && wHaveFf && !bvalidFf) begin
      nxt_awHave = 1'b0;
      nxt_wHave = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = OSP_RESP_OKAY;
      case (awAddrFf)
        OSP_OFF_PIN0_CFG: nxt_cfg[0] = applyStrb(cfgFf[0], wDataFf, wStrbFf) & OSP_CFG_MASK;
        OSP_OFF_PIN1_CFG: nxt_cfg[1] = applyStrb(cfgFf[1], wDataFf, wStrbFf) & OSP_CFG_MASK;
        OSP_OFF_PIN0_PWM: nxt_pwmReg[0] = applyStrb(pwmFf[0], wDataFf, wStrbFf);
        OSP_OFF_PIN1_PWM: nxt_pwmReg[1] = applyStrb(pwmFf[1], wDataFf, wStrbFf);
        OSP_OFF_OUT_CTL: begin
          onReq = wStrbFf[0] && wDataFf[OSP_CTL_ON_BIT];
          offReq = wStrbFf[0] && wDataFf[OSP_CTL_OFF_BIT];
        end
        OSP_OFF_STATUS: nxt_bresp = OSP_RESP_OKAY;
        default: nxt_bresp = OSP_RESP_SLVERR;
      endcase
    end
    nxt_awready = !nxt_awHave && !nxt_bvalid;
    nxt_wready = !nxt_wHave && !nxt_bvalid;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfgFf <= {OSP_NPINS{OSP_CFG_RST}};
      pwmFf <= {OSP_NPINS{OSP_PWM_RST}};
      awHaveFf <= 1'b0;
      awAddrFf <= '0;
      wHaveFf <= 1'b0;
      wDataFf <= '0;
      wStrbFf <= '0;
      awreadyFf <= 1'b0;
      wreadyFf <= 1'b0;
      bvalidFf <= 1'b0;
      brespFf <= OSP_RESP_OKAY;
    end else if (ce) begin
      cfgFf <= nxt_cfg;
      pwmFf <= nxt_pwmReg;
      awHaveFf <= nxt_awHave;
      awAddrFf <= nxt_awAddr;
      wHaveFf <= nxt_wHave;
      wDataFf <= nxt_wData;
      wStrbFf <= nxt_wStrb;
      awreadyFf <= nxt_awready;
      wreadyFf <= nxt_wready;
      bvalidFf <= nxt_bvalid;
      brespFf <= nxt_bresp;
    end
  end

  // axi4-lite read side
  always_comb begin
    nxt_rvalid = rvalidFf;
    nxt_rdata = rdataFf;
    nxt_rresp = rrespFf;
    if (rvalidFf && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arreadyFf) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = OSP_RESP_OKAY;
      case (s_axi_araddr)
        OSP_OFF_PIN0_CFG: nxt_rdata = cfgFf[0];
        OSP_OFF_PIN1_CFG: nxt_rdata = cfgFf[1];
        OSP_OFF_PIN0_PWM: nxt_rdata = pwmFf[0];
        OSP_OFF_PIN1_PWM: nxt_rdata = pwmFf[1];
        OSP_OFF_OUT_CTL: nxt_rdata = '0;
        OSP_OFF_STATUS: nxt_rdata = statusWord;
        default: begin
          nxt_rdata = '0;
          nxt_rresp = OSP_RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      arreadyFf <= 1'b0;
      rvalidFf <= 1'b0;
      rdataFf <= '0;
      rrespFf <= OSP_RESP_OKAY;
    end else if (ce) begin
      arreadyFf <= nxt_arready;
      rvalidFf <= nxt_rvalid;
      rdataFf <= nxt_rdata;
      rrespFf <= nxt_rresp;
    end
  end

  // output state, sync pulses and pin drive
  always_comb begin
    turnOn = onReq || (cfgMode(cfgFf[0]) == OSP_MODE_SYNC && rxPulse[0]);
    turnOff = offReq || (cfgMode(cfgFf[1]) == OSP_MODE_SYNC && rxPulse[1]);
    nxt_outOn = outOnFf;
    // a pulse of the wrong kind for the current state is simply ignored
    if (outOnFf && turnOff) begin
      nxt_outOn = 1'b0;
    end else if (!outOnFf && turnOn) begin
      nxt_outOn = 1'b1;
    end
    for (int i = 0; i < OSP_NPINS; i++) begin
      nxt_txCnt[i] = txActive[i] ? txCntFf[i] - 1'b1 : txCntFf[i];
    end
    if (nxt_outOn && !outOnFf && cfgMode(cfgFf[0]) == OSP_MODE_SYNC) begin
      nxt_txCnt[0] = OSP_CNT_W'(TX_PULSE_CYC);
    end
    if (!nxt_outOn && outOnFf && cfgMode(cfgFf[1]) == OSP_MODE_SYNC) begin
      nxt_txCnt[1] = OSP_CNT_W'(TX_PULSE_CYC);
    end
    for (int i = 0; i < OSP_NPINS; i++) begin
      {nxt_pinOe[i], nxt_pinOut[i]} = pinDrive(cfgFf[i], pwmBit[i], nxt_txCnt[i] != '0);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      outOnFf <= 1'b0;
      txCntFf <= '0;
      pinOutFf <= '0;
      pinOeFf <= '0;
    end else if (ce) begin
      outOnFf <= nxt_outOn;
      txCntFf <= nxt_txCnt;
      pinOutFf <= nxt_pinOut;
      pinOeFf <= nxt_pinOe;
    end
  end

  assign s_axi_awready = awreadyFf;
  assign s_axi_wready = wreadyFf;
  assign s_axi_bresp = brespFf;
  assign s_axi_bvalid = bvalidFf;
  assign s_axi_arready = arreadyFf;
  assign s_axi_rdata = rdataFf;
  assign s_axi_rresp = rrespFf;
  assign s_axi_rvalid = rvalidFf;
  assign syncOnPinOut = pinOutFf[0];
  assign syncOnPinOe = pinOeFf[0];
  assign syncOffPinOut = pinOutFf[1];
  assign syncOffPinOe = pinOeFf[1];
  assign outputOn = outOnFf;
endmodule // osp_top
